// file: rtl/csrcfg_pkg.sv
// Behaviour
// RULE1 - Seven back-channel alarm enables, reset cleared
// RULE2 - Swap P/N for clock and data lanes
// RULE3 - Separate low-power polarity for clock, data lanes
// RULE4 - Software keeps high-speed debug enable zero
// RULE5 - Low-power debug enable: top bit read-only
// RULE6 - Per-lane termination enables, reset zero
// RULE7 - Header source: corrected or as received
// RULE8 - Record headers per virtual channel when set
// RULE9 - Channel select works only with per-channel record
// RULE10 - Ignore low-power states until start interval ends
// RULE11 - Interval in 100 us steps, code plus one
// RULE12 - One inverts; reserved bits keep reset values
package csrcfg_pkg;
	// Register byte offsets
	localparam logic [7:0] CSRCFG_ALARM_ADDR = 8'h1e;
	localparam logic [7:0] CSRCFG_RSV1F_ADDR = 8'h1f;
	localparam logic [7:0] CSRCFG_SWAP_ADDR = 8'h20;
	localparam logic [7:0] CSRCFG_LPPOL_ADDR = 8'h21;
	localparam logic [7:0] CSRCFG_HSDBG_ADDR = 8'h22;
	localparam logic [7:0] CSRCFG_LPDBG_ADDR = 8'h23;
	localparam logic [7:0] CSRCFG_TERM_ADDR = 8'h24;
	localparam logic [7:0] CSRCFG_RSV25_ADDR = 8'h25;
	localparam logic [7:0] CSRCFG_RSV26_ADDR = 8'h26;
	localparam logic [7:0] CSRCFG_RSV27_ADDR = 8'h27;
	localparam logic [7:0] CSRCFG_RSV28_ADDR = 8'h28;
	localparam logic [7:0] CSRCFG_RSV29_ADDR = 8'h29;
	localparam logic [7:0] CSRCFG_RSV2A_ADDR = 8'h2a;
	localparam logic [7:0] CSRCFG_RSV2B_ADDR = 8'h2b;
	localparam logic [7:0] CSRCFG_RSV2D_ADDR = 8'h2d;
	localparam logic [7:0] CSRCFG_RSV2E_ADDR = 8'h2e;
	localparam logic [7:0] CSRCFG_RSV30_ADDR = 8'h30;
	localparam logic [7:0] CSRCFG_HDRCTL_ADDR = 8'h31;
	// Header capture readback, interrupt and start status
	localparam logic [7:0] CSRCFG_HDR0_ADDR = 8'h38;
	localparam logic [7:0] CSRCFG_HDR1_ADDR = 8'h39;
	localparam logic [7:0] CSRCFG_HDR2_ADDR = 8'h3a;
	localparam logic [7:0] CSRCFG_HDR3_ADDR = 8'h3b;
	localparam logic [7:0] CSRCFG_IRQST_ADDR = 8'h3c;
	localparam logic [7:0] CSRCFG_IRQMSK_ADDR = 8'h3d;
	localparam logic [7:0] CSRCFG_INITST_ADDR = 8'h3e;
	// Reset values
	localparam logic [7:0] CSRCFG_ZERO = 8'h00;
	localparam logic [7:0] CSRCFG_RSV25_RST = 8'h02;
	localparam logic [7:0] CSRCFG_RSV28_RST = 8'h07;
	localparam logic [7:0] CSRCFG_RSV29_RST = 8'h33;
	localparam logic [7:0] CSRCFG_RSV2A_RST = 8'h01;
	localparam logic [7:0] CSRCFG_HDRCTL_RST = 8'h20;
	// Field layout
	localparam int CSRCFG_ALARM_W = 7;
	localparam int CSRCFG_SWAP_W = 5;
	localparam int CSRCFG_DBG_W = 7;
	localparam int CSRCFG_LANES = 4;
	localparam int CSRCFG_CLK_BIT = 4;
	localparam int CSRCFG_SEL_LSB = 6;
	localparam int CSRCFG_SRC_BIT = 5;
	localparam int CSRCFG_VCI_BIT = 4;
	localparam int CSRCFG_TINIT_W = 3;
	localparam int CSRCFG_HDR_W = 32;
	localparam int CSRCFG_VC_N = 4;
	localparam int CSRCFG_IRQ_W = 2;
	localparam int CSRCFG_IRQ_INIT = 0;
	localparam int CSRCFG_IRQ_HDR = 1;
	// Timing
	localparam int CSRCFG_STEP_US = 100;
	localparam int CSRCFG_CLK_MHZ = 40;
	localparam int CSRCFG_STEP_CYC = CSRCFG_STEP_US * CSRCFG_CLK_MHZ;
	// Start-up state, Gray along the path
	typedef enum logic [1:0] {
		CSRCFG_WAIT = 2'b00,
		CSRCFG_RUN = 2'b01
	} csrcfg_init_e;
endpackage

// file: rtl/csrcfg_top.sv
`timescale 1ns/1ps
module csrcfg_top
	import csrcfg_pkg::*;
#(
	parameter int STEP_CYCLES = CSRCFG_STEP_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rd_data,
	// Lane pins from the sensor
	input wire logic csi_clk_in,
	input wire logic [3:0] csi_hs_in,
	input wire logic csi_lp_clk_in,
	input wire logic [3:0] csi_lp_in,
	// Captured packet headers
	input wire logic hdr_valid,
	input wire logic [1:0] hdr_vc,
	input wire logic [31:0] hdr_raw,
	input wire logic [31:0] hdr_fixed,
	// Lane data towards the datapath
	output logic [3:0] hs_data,
	output logic hs_strobe,
	output logic lp_clk_out,
	output logic [3:0] lp_data_out,
	// Configuration outputs
	output logic [6:0] bc_alarm_en,
	output logic [3:0] lane_termination_on,
	output logic [6:0] hs_rx_debug_en,
	output logic [6:0] lp_rx_debug_en,
	output logic startup_done,
	// Interrupt
	output logic irq
);
	// Software registers
	logic [6:0] alarm_reg;
	logic [4:0] swap_reg;
	logic [4:0] lppol_reg;
	logic [6:0] hsdbg_reg;
	logic [6:0] lpdbg_reg;
	logic [3:0] term_reg;
	logic [7:0] hdrctl_reg;
	logic [1:0] irq_st_reg;
	logic [1:0] irq_st_next;
	logic [1:0] irq_msk_reg;
	// Header slots, one per virtual channel
	logic [31:0] hdr_mem [CSRCFG_VC_N];
	// Synchronisers and edge finder
	logic [4:0] hs_s1_reg;
	logic [4:0] hs_s2_reg;
	logic [4:0] lp_s1_reg;
	logic [4:0] lp_s2_reg;
	logic clk_prev_reg;
	// Start-up timer
	csrcfg_init_e init_reg;
	logic [12:0] cyc_reg;
	logic [3:0] step_reg;
	logic done_reg; // Start-up over, feeds the output flop-direct
	// Output flops
	logic [7:0] rd_data_reg;
	logic [3:0] hs_data_reg;
	logic hs_strobe_reg;
	logic lp_clk_reg;
	logic [3:0] lp_data_reg;
	logic irq_reg;
	// Decoded helpers
	logic wr_alarm;
	logic [1:0] hdr_rd_slot;
	logic [31:0] hdr_view;
	logic [4:0] hs_pol;
	logic clk_rise;
	logic [3:0] step_goal;

	assign wr_alarm = reg_wr && (reg_addr == CSRCFG_ALARM_ADDR);
	// Slot exposed on readback
	assign hdr_rd_slot = hdrctl_reg[CSRCFG_VCI_BIT] ?
		hdrctl_reg[CSRCFG_SEL_LSB +: 2] : 2'h0; // RULE9
	assign hdr_view = hdr_mem[hdr_rd_slot];
	// High-speed levels after swap, one inverts
	assign hs_pol = hs_s2_reg ^ swap_reg; // RULE2 RULE12
	assign clk_rise = hs_pol[CSRCFG_CLK_BIT] && !clk_prev_reg;
	// Number of 100 us steps to wait
	assign step_goal = {1'b0, hdrctl_reg[CSRCFG_TINIT_W-1:0]} + 4'h1; // RULE11

	// Back-channel alarm enables
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alarm_reg <= '0; // RULE1
		end else if (wr_alarm) begin
			alarm_reg <= reg_wr_data[CSRCFG_ALARM_W-1:0]; // RULE1
		end
	end

	// Lane polarity and low-power polarity
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			swap_reg <= '0; // RULE2
			lppol_reg <= '0; // RULE3
		end else if (reg_wr) begin
			if (reg_addr == CSRCFG_SWAP_ADDR) begin
				swap_reg <= reg_wr_data[CSRCFG_SWAP_W-1:0]; // RULE2
			end
			if (reg_addr == CSRCFG_LPPOL_ADDR) begin
				lppol_reg <= reg_wr_data[CSRCFG_SWAP_W-1:0]; // RULE3
			end
		end
	end

	// Debug enables and termination; top bits stay read-only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hsdbg_reg <= '0;
			lpdbg_reg <= '0; // RULE5
			term_reg <= '0; // RULE6
		end else if (reg_wr) begin
			if (reg_addr == CSRCFG_HSDBG_ADDR) begin
				hsdbg_reg <= reg_wr_data[CSRCFG_DBG_W-1:0];
			end
			if (reg_addr == CSRCFG_LPDBG_ADDR) begin
				lpdbg_reg <= reg_wr_data[CSRCFG_DBG_W-1:0]; // RULE5
			end
			if (reg_addr == CSRCFG_TERM_ADDR) begin
				term_reg <= reg_wr_data[CSRCFG_LANES-1:0]; // RULE6
			end
		end
	end

	// Header control; bit 3 is reserved and held at zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hdrctl_reg <= CSRCFG_HDRCTL_RST; // RULE7
		end else if (reg_wr && reg_addr == CSRCFG_HDRCTL_ADDR) begin
			hdrctl_reg <= reg_wr_data & 8'hf7; // RULE12
		end
	end

	// Header recording into per-channel slots
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < CSRCFG_VC_N; i++) begin
				hdr_mem[i] <= '0;
			end
		end else if (hdr_valid) begin
			// Interleaved mode keys the slot on the channel
			if (hdrctl_reg[CSRCFG_VCI_BIT]) begin
				hdr_mem[hdr_vc] <= hdrctl_reg[CSRCFG_SRC_BIT] ?
					hdr_fixed : hdr_raw; // RULE8 RULE7
			end else begin
				hdr_mem[0] <= hdrctl_reg[CSRCFG_SRC_BIT] ?
					hdr_fixed : hdr_raw; // RULE7
			end
		end
	end

	// Interrupt status: hardware set wins over write-one clear
	always_comb begin
		irq_st_next = irq_st_reg;
		if (reg_wr && reg_addr == CSRCFG_IRQST_ADDR) begin
			irq_st_next = irq_st_reg & ~reg_wr_data[CSRCFG_IRQ_W-1:0];
		end
		if (hdr_valid) begin
			irq_st_next[CSRCFG_IRQ_HDR] = 1'b1;
		end
		if (init_reg == CSRCFG_WAIT && step_reg >= step_goal) begin
			irq_st_next[CSRCFG_IRQ_INIT] = 1'b1;
		end
	end

	// Interrupt status, mask and level output
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_st_reg <= '0;
			irq_msk_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			irq_st_reg <= irq_st_next;
			if (reg_wr && reg_addr == CSRCFG_IRQMSK_ADDR) begin
				irq_msk_reg <= reg_wr_data[CSRCFG_IRQ_W-1:0];
			end
			irq_reg <= |(irq_st_reg & irq_msk_reg);
		end
	end

	// Start-up interval timer, counted from reset release
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			init_reg <= CSRCFG_WAIT;
			cyc_reg <= '0;
			step_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			unique case (init_reg)
				CSRCFG_WAIT: begin
					// Interval ends after code plus one steps
					if (step_reg >= step_goal) begin
						init_reg <= CSRCFG_RUN; // RULE10
						done_reg <= 1'b1; // RULE10
					end else if (cyc_reg == 13'(STEP_CYCLES - 1)) begin
						cyc_reg <= '0;
						step_reg <= step_reg + 4'h1; // RULE11
					end else begin
						cyc_reg <= cyc_reg + 13'h1;
					end
				end
				CSRCFG_RUN: begin
					init_reg <= CSRCFG_RUN;
				end
			endcase
		end
	end

	// Two-stage synchronisers for every lane pin
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hs_s1_reg <= '0;
			hs_s2_reg <= '0;
			lp_s1_reg <= 5'h1f;
			lp_s2_reg <= 5'h1f;
		end else begin
			hs_s1_reg <= {csi_clk_in, csi_hs_in};
			hs_s2_reg <= hs_s1_reg;
			lp_s1_reg <= {csi_lp_clk_in, csi_lp_in};
			lp_s2_reg <= lp_s1_reg;
		end
	end

	// Sample data lanes on each rising edge of the lane clock
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			clk_prev_reg <= 1'b0;
			hs_data_reg <= '0;
			hs_strobe_reg <= 1'b0;
		end else begin
			clk_prev_reg <= hs_pol[CSRCFG_CLK_BIT];
			hs_strobe_reg <= clk_rise;
			if (clk_rise) begin
				hs_data_reg <= hs_pol[CSRCFG_LANES-1:0]; // RULE2
			end
		end
	end

	// Low-power levels: held at stop state until start-up ends
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lp_clk_reg <= 1'b1;
			lp_data_reg <= '1;
		end else if (init_reg == CSRCFG_RUN) begin
			lp_clk_reg <= lp_s2_reg[CSRCFG_CLK_BIT] ^
				lppol_reg[CSRCFG_CLK_BIT]; // RULE3 RULE10
			lp_data_reg <= lp_s2_reg[CSRCFG_LANES-1:0] ^
				lppol_reg[CSRCFG_LANES-1:0]; // RULE3 RULE12
		end else begin
			lp_clk_reg <= 1'b1; // RULE10
			lp_data_reg <= '1;
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset || !reg_rd) begin
			rd_data_reg <= '0;
		end else begin
			unique case (reg_addr)
				CSRCFG_ALARM_ADDR: rd_data_reg <= {1'b0, alarm_reg};
				CSRCFG_SWAP_ADDR: rd_data_reg <= {3'h0, swap_reg};
				CSRCFG_LPPOL_ADDR: rd_data_reg <= {3'h0, lppol_reg};
				CSRCFG_HSDBG_ADDR: rd_data_reg <= {1'b0, hsdbg_reg};
				CSRCFG_LPDBG_ADDR: rd_data_reg <= {1'b0, lpdbg_reg}; // RULE5
				CSRCFG_TERM_ADDR: rd_data_reg <= {4'h0, term_reg};
				// Reserved registers return their reset values
				CSRCFG_RSV25_ADDR: rd_data_reg <= CSRCFG_RSV25_RST; // RULE12
				CSRCFG_RSV28_ADDR: rd_data_reg <= CSRCFG_RSV28_RST;
				CSRCFG_RSV29_ADDR: rd_data_reg <= CSRCFG_RSV29_RST;
				CSRCFG_RSV2A_ADDR: rd_data_reg <= CSRCFG_RSV2A_RST;
				CSRCFG_HDRCTL_ADDR: rd_data_reg <= hdrctl_reg;
				CSRCFG_HDR0_ADDR: rd_data_reg <= hdr_view[7:0]; // RULE9
				CSRCFG_HDR1_ADDR: rd_data_reg <= hdr_view[15:8];
				CSRCFG_HDR2_ADDR: rd_data_reg <= hdr_view[23:16];
				CSRCFG_HDR3_ADDR: rd_data_reg <= hdr_view[31:24];
				CSRCFG_IRQST_ADDR: rd_data_reg <= {6'h00, irq_st_reg};
				CSRCFG_IRQMSK_ADDR: rd_data_reg <= {6'h00, irq_msk_reg};
				CSRCFG_INITST_ADDR: begin
					rd_data_reg <= {7'h00, init_reg == CSRCFG_RUN};
				end
				// Other reserved and unmapped addresses read zero
				default: rd_data_reg <= CSRCFG_ZERO;
			endcase
		end
	end

	// Outputs straight from flops
	assign reg_rd_data = rd_data_reg;
	assign hs_data = hs_data_reg;
	assign hs_strobe = hs_strobe_reg;
	assign lp_clk_out = lp_clk_reg;
	assign lp_data_out = lp_data_reg;
	assign bc_alarm_en = alarm_reg;
	assign lane_termination_on = term_reg;
	assign hs_rx_debug_en = hsdbg_reg; // RULE4
	assign lp_rx_debug_en = lpdbg_reg;
	assign startup_done = done_reg;
	assign irq = irq_reg;

	// Register write then read of the same address
	sequence s_write_alarm;
		wr_alarm ##1 !reg_wr ##1 reg_rd && reg_addr == CSRCFG_ALARM_ADDR;
	endsequence

	sequence s_read_swap;
		reg_rd && reg_addr == CSRCFG_SWAP_ADDR;
	endsequence

	a_alarm_reset_val: assert property (@(posedge sys_clk) // RULE1
		$fell(reset) |-> alarm_reg == '0)
		else $error("alarm enables not cleared by reset");

	a_alarm_write_back: assert property (@(posedge sys_clk) // RULE1
		disable iff (reset)
		s_write_alarm |=> reg_rd_data == {1'b0, $past(reg_wr_data, 3)})
		else $error("alarm enable readback differs from write");

	a_swap_read_back: assert property (@(posedge sys_clk) // RULE2
		disable iff (reset)
		s_read_swap |=> reg_rd_data[7:5] == 3'h0 &&
			reg_rd_data[4:0] == swap_reg)
		else $error("swap register readback wrong");

	a_hs_lane_swap: assert property (@(posedge sys_clk) // RULE2
		disable iff (reset)
		clk_rise |=> hs_strobe && hs_data == $past(hs_pol[3:0]))
		else $error("high-speed lane not swapped as set");

	a_lp_hold_stop: assert property (@(posedge sys_clk) // RULE10
		disable iff (reset)
		!startup_done |=> lp_data_out == 4'hf && lp_clk_out)
		else $error("low-power state passed during start-up");

	a_lp_polarity: assert property (@(posedge sys_clk) // RULE3
		disable iff (reset)
		startup_done |=> lp_data_out ==
			($past(lp_s2_reg[3:0]) ^ $past(lppol_reg[3:0])))
		else $error("low-power polarity not applied");

	a_init_not_early: assert property (@(posedge sys_clk) // RULE11
		disable iff (reset)
		step_reg < step_goal |=> !startup_done || $past(startup_done))
		else $error("start-up ended before its interval");

	a_lpdbg_top_bit: assert property (@(posedge sys_clk) // RULE5
		disable iff (reset)
		reg_rd && reg_addr == CSRCFG_LPDBG_ADDR |=> !reg_rd_data[7])
		else $error("read-only top bit read as one");

	a_term_reset_val: assert property (@(posedge sys_clk) // RULE6
		$fell(reset) |-> lane_termination_on == 4'h0)
		else $error("termination enables not cleared by reset");

	a_hdr_select: assert property (@(posedge sys_clk) // RULE9
		disable iff (reset)
		!hdrctl_reg[CSRCFG_VCI_BIT] |-> hdr_rd_slot == 2'h0)
		else $error("channel select used without per-channel record");

	a_hdr_source: assert property (@(posedge sys_clk) // RULE7
		disable iff (reset)
		hdr_valid && !hdrctl_reg[CSRCFG_VCI_BIT] |=>
			hdr_mem[0] == ($past(hdrctl_reg[CSRCFG_SRC_BIT]) ?
			$past(hdr_fixed) : $past(hdr_raw)))
		else $error("header source selection wrong");

	a_rsv_read_val: assert property (@(posedge sys_clk) // RULE12
		disable iff (reset)
		reg_rd && reg_addr == CSRCFG_RSV29_ADDR |=>
			reg_rd_data == CSRCFG_RSV29_RST)
		else $error("reserved register lost its reset value");

	a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
		##1 irq == |($past(irq_st_reg) & $past(irq_msk_reg)))
		else $error("interrupt does not follow masked status");
endmodule

// file: tb/csi2_rx_config_alarm_regs_tb.sv
`timescale 1ns/1ps
module csi2_rx_config_alarm_regs_tb;
	import csrcfg_pkg::*;
	// Short start-up step keeps the run brief
	localparam int STEP = 8;
	// Register port, headers and design outputs
	logic sys_clk, reset, reg_wr, reg_rd, hdr_valid;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
	logic [1:0] hdr_vc;
	logic [31:0] hdr_raw, hdr_fixed;
	logic csi_clk_in, csi_lp_clk_in, hs_strobe, lp_clk_out;
	logic startup_done, irq;
	logic [3:0] csi_hs_in, csi_lp_in, hs_data, lp_data_out;
	logic [3:0] lane_termination_on;
	logic [6:0] bc_alarm_en, hs_rx_debug_en, lp_rx_debug_en;
	// Scoreboard state
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [7:0] rd_q[$];
	logic [3:0] hs_q[$];
	logic rd_pend = 1'b0;
	logic swp_lvl = 1'b0;
	logic [4:0] swap_b = 5'h00;
	integer seed = 32'h920e_b70d;
	logic [7:0] d;
	logic [31:0] h;
	int n;
	// Register table: offset, reset value, writable mask
	logic [2:0] codes[3] = '{3'h7, 3'h2, 3'h0};
	logic [7:0] ra[16] = '{8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23,
		8'h24, 8'h25, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h30, 8'h31, 8'h3d, 8'h00};
	logic [7:0] rr[16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h02, 8'h07, 8'h33, 8'h01, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
	logic [7:0] rm[16] = '{8'h7f, 8'h00, 8'h1f, 8'h1f, 8'h7f, 8'h7f,
		8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf7, 8'h03, 8'h00};

	// Design under test
	csrcfg_top #(.STEP_CYCLES(STEP)) dut (
		.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rd_data(reg_rd_data), .csi_clk_in(csi_clk_in),
		.csi_hs_in(csi_hs_in), .csi_lp_clk_in(csi_lp_clk_in),
		.csi_lp_in(csi_lp_in), .hdr_valid(hdr_valid), .hdr_vc(hdr_vc),
		.hdr_raw(hdr_raw), .hdr_fixed(hdr_fixed), .hs_data(hs_data),
		.hs_strobe(hs_strobe), .lp_clk_out(lp_clk_out),
		.lp_data_out(lp_data_out), .bc_alarm_en(bc_alarm_en),
		.lane_termination_on(lane_termination_on),
		.hs_rx_debug_en(hs_rx_debug_en), .lp_rx_debug_en(lp_rx_debug_en),
		.startup_done(startup_done), .irq(irq));
	// Sensor on the lane side
	csrcfg_sensor sensor (.csi_clk_in(csi_clk_in), .csi_hs_in(csi_hs_in),
		.csi_lp_clk_in(csi_lp_clk_in), .csi_lp_in(csi_lp_in));

	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Count and report one comparison
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Read data against the oldest noted byte; a missing note fails
	task automatic chk_rd(input logic [7:0] g);
		logic [7:0] e;
		e = (rd_q.size() > 0) ? rd_q.pop_front() : ~g;
		chk(32'(g), 32'(e));
	endtask
	// Lane sample against the oldest noted word; a stray strobe fails
	task automatic chk_hs(input logic [3:0] g);
		logic [3:0] e;
		e = (hs_q.size() > 0) ? hs_q.pop_front() : ~g;
		chk(32'(g), 32'(e));
	endtask
	// Counts, verdict and end of run
	task automatic print_verdict;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle register read, expected byte noted first
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	// Header readback, low byte first
	task automatic rd32(input logic [31:0] e);
		for (int i = 0; i < 4; i++)
			rd(CSRCFG_HDR0_ADDR + 8'(i), e[8*i+:8]);
	endtask
	// One captured header; corrected copy is the inverse
	task automatic hdr(input logic [1:0] vc, input logic [31:0] r);
		@(posedge sys_clk);
		hdr_valid <= 1'b1;
		hdr_vc <= vc;
		hdr_raw <= r;
		hdr_fixed <= ~r;
		@(posedge sys_clk);
		hdr_valid <= 1'b0;
	endtask

	// Output watcher: read data the cycle after a strobe, lane samples
	always @(posedge sys_clk) begin
		if (rd_pend)
			chk_rd(reg_rd_data);
		rd_pend <= reg_rd;
		if (hs_strobe)
			chk_hs(hs_data);
	end
	// Note a sample at each rise of the clock lane after its swap
	always @(csi_clk_in or swap_b) begin
		if ((csi_clk_in ^ swap_b[4]) && !swp_lvl)
			hs_q.push_back(csi_hs_in ^ swap_b[3:0]);
		swp_lvl = csi_clk_in ^ swap_b[4];
	end
	// Cuts a hang short
	initial begin
		#1_000_000;
		n_mismatch++;
		print_verdict();
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		{reg_wr, reg_rd, hdr_valid, reg_addr, reg_wr_data} = '0;
		{hdr_vc, hdr_raw, hdr_fixed} = '0;
		// Start-up interval per code, each after its own reset
		foreach (codes[i]) begin
			reset <= 1'b1;
			repeat (5) @(posedge sys_clk);
			reset <= 1'b0;
			wr(CSRCFG_HDRCTL_ADDR, 8'h20 | 8'(codes[i]));
			n = 1;
			while (startup_done !== 1'b1 && n < 200) begin
				if (n == 2)
					chk({lp_clk_out, lp_data_out}, 5'h1f);
				@(posedge sys_clk);
				n++;
			end
			h = (codes[i] + 1) * STEP;
			chk(n >= h - 2 && n <= h + 4, 1);
		end
		rd(CSRCFG_IRQST_ADDR, 8'h01);
		rd(CSRCFG_INITST_ADDR, 8'h01);
		// Reset values, then random writes over the table
		foreach (ra[i]) begin
			rd(ra[i], rr[i]);
			d = 8'($random(seed));
			wr(ra[i], d);
			if (ra[i] == CSRCFG_SWAP_ADDR)
				swap_b = d[4:0];
			rd(ra[i], (d & rm[i]) | (rr[i] & ~rm[i]));
		end
		// Configuration outputs follow their registers
		wr(8'h1e, 8'hd5);
		wr(8'h24, 8'hfa);
		wr(8'h23, 8'hff);
		wr(8'h22, 8'h00);
		@(posedge sys_clk);
		chk(bc_alarm_en, 7'h55);
		chk(lane_termination_on, 4'ha);
		chk(lp_rx_debug_en, 7'h7f);
		chk(hs_rx_debug_en, 7'h00);
		// Low-power polarity
		sensor.lp_set(1'b1, 4'h6);
		repeat (3) begin
			d = 8'($random(seed));
			wr(CSRCFG_LPPOL_ADDR, d);
			repeat (5) @(posedge sys_clk);
			chk({lp_clk_out, lp_data_out}, 5'h16 ^ d[4:0]);
		end
		// High-speed frames under random swaps
		repeat (4) begin
			d = 8'($random(seed));
			wr(CSRCFG_SWAP_ADDR, d);
			swap_b = d[4:0];
			repeat (4) @(posedge sys_clk);
			sensor.burst(6);
			repeat (8) @(posedge sys_clk);
		end
		chk(hs_q.size(), 0);
		// Corrected versus received header, capture interrupt
		wr(CSRCFG_IRQMSK_ADDR, 8'h00);
		wr(CSRCFG_HDRCTL_ADDR, 8'h20);
		h = $random(seed);
		hdr(2'h2, h);
		rd32(~h);
		chk(irq, 0);
		wr(CSRCFG_IRQMSK_ADDR, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1);
		wr(CSRCFG_IRQST_ADDR, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk(irq, 0);
		wr(CSRCFG_HDRCTL_ADDR, 8'h00);
		hdr(2'h1, h + 32'h11);
		rd32(h + 32'h11);
		// Per-channel capture and channel select
		wr(CSRCFG_HDRCTL_ADDR, 8'h30);
		for (int v = 0; v < 4; v++)
			hdr(2'(v), h + 32'(v));
		for (int v = 0; v < 4; v++) begin
			wr(CSRCFG_HDRCTL_ADDR, {2'(v), 6'h30});
			rd32(~(h + 32'(v)));
		end
		wr(CSRCFG_HDRCTL_ADDR, 8'he0);
		rd32(~h);
		repeat (4) @(posedge sys_clk);
		print_verdict();
	end
endmodule

// file: tb/csrcfg_sensor.sv
`timescale 1ns/1ps
module csrcfg_sensor (
	// Lane pins towards the receiver
	output logic csi_clk_in,
	output logic [3:0] csi_hs_in,
	output logic csi_lp_clk_in,
	output logic [3:0] csi_lp_in
);
	// Next word put on the data lanes
	logic [3:0] pat_reg = 4'h9;
	// Clock parked low between frames, lanes stay driven
	initial begin
		csi_clk_in = 1'b0;
		csi_hs_in = 4'h0;
		csi_lp_clk_in = 1'b0;
		csi_lp_in = 4'h0;
	end
	// Frame of n periods of 200 ns; data moves 50 ns after the rise
	// so that both clock edges see settled lanes
	task automatic burst(input int n);
		#7;
		repeat (n) begin
			csi_clk_in = 1'b1;
			#50;
			csi_hs_in = pat_reg;
			pat_reg = pat_reg + 4'h7;
			#50;
			csi_clk_in = 1'b0;
			#100;
		end
	endtask
	// Low-power line levels
	task automatic lp_set(input logic c, input logic [3:0] v);
		csi_lp_clk_in <= c;
		csi_lp_in <= v;
	endtask
endmodule
